// >>> rtl/tec_pkg.sv
// Shared constants and types for the tap event configuration and status block
package tec_pkg;
   // Register offsets on the device register port
   localparam logic [7:0] TEC_CONFIG_ADDR = 8'h21;
   localparam logic [7:0] TEC_STATUS_ADDR = 8'h22;
   // Configuration field positions
   localparam int TEC_CFG_ABORT = 7;
   localparam int TEC_CFG_LATCH = 6;
   localparam int TEC_CFG_Z_DBL = 5;
   localparam int TEC_CFG_Z_SGL = 4;
   localparam int TEC_CFG_Y_DBL = 3;
   localparam int TEC_CFG_Y_SGL = 2;
   localparam int TEC_CFG_X_DBL = 1;
   localparam int TEC_CFG_X_SGL = 0;
   // Status field positions
   localparam int TEC_ST_ACTIVE = 7;
   localparam int TEC_ST_Z_FLAG = 6;
   localparam int TEC_ST_X_FLAG = 4;
   localparam int TEC_ST_DOUBLE = 3;
   localparam int TEC_ST_Z_NEG = 2;
   localparam int TEC_ST_X_NEG = 0;
   // Values after reset
   localparam logic [7:0] TEC_CONFIG_RST = 8'h00;
   localparam logic [7:0] TEC_STATUS_RST = 8'h00;
   localparam logic [7:0] TEC_RDATA_RST = 8'h00;
   // Timer step of the latency and window counters
   localparam int TEC_CLK_PERIOD_PS = 4000;
   localparam longint TEC_STEP_TIME_PS = 64'd2500000000;
   localparam int TEC_STEP_CYCLES = int'((TEC_STEP_TIME_PS + TEC_CLK_PERIOD_PS - 1)
                                         / TEC_CLK_PERIOD_PS);
   // Tap sequencer states
   typedef enum logic [1:0] {
      TEC_SQ_IDLE,
      TEC_SQ_LATENCY,
      TEC_SQ_WINDOW
   } tec_seq_state_t;
endpackage

// >>> rtl/tec_evt_if.sv
// Tap event and sequencer control signals between sequencer and status logic
`timescale 1ns/1ps
interface tec_evt_if;
   logic single_evt;
   logic double_evt;
   logic [2:0] axis;
   logic [2:0] negative;
   logic double_tap_abort;
   logic [7:0] tap_latency_time;
   logic [7:0] window_time;
   modport seq (output single_evt, double_evt, axis, negative,
                input double_tap_abort, tap_latency_time, window_time);
   modport ctl (input single_evt, double_evt, axis, negative,
                output double_tap_abort, tap_latency_time, window_time);
endinterface

// >>> rtl/tec_tap_seq.sv
// Single and double tap sequencer with latency interval and abort option
`timescale 1ns/1ps
module tec_tap_seq
   import tec_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Timer step enable
   input wire logic tick,
   // Pulses per axis, bit 2 Z, bit 1 Y, bit 0 X
   input wire logic [2:0] pulse_start,
   input wire logic [2:0] pulse_done,
   input wire logic [2:0] pulse_neg,
   // Events out, control in
   tec_evt_if.seq evt
);
   typedef struct packed {
      tec_seq_state_t state;
      logic [7:0] cnt;
      logic lat_start;
      logic lat_abort;
      logic single_evt;
      logic double_evt;
      logic [2:0] axis;
      logic [2:0] negative;
   } tec_seq_t;

   tec_seq_t s_reg;
   tec_seq_t s_next;

   always_comb begin
      s_next = s_reg;
      s_next.single_evt = 1'b0;
      s_next.double_evt = 1'b0;
      case (s_reg.state)
         TEC_SQ_IDLE: begin
            if (|pulse_done) begin
               s_next.single_evt = 1'b1;
               s_next.axis = pulse_done;
               s_next.negative = pulse_neg & pulse_done;
               s_next.cnt = evt.tap_latency_time;
               s_next.lat_start = 1'b0;
               s_next.lat_abort = 1'b0;
               s_next.state = TEC_SQ_LATENCY;
            end
         end
         TEC_SQ_LATENCY: begin
            // Pulses here are only tracked, never reported
            if (|pulse_start) begin
               s_next.lat_start = 1'b1;
            end
            if ((s_reg.lat_start || |pulse_start) && |pulse_done && evt.double_tap_abort) begin
               s_next.lat_abort = 1'b1;
            end
            if (tick) begin
               if (s_reg.cnt == 8'h00) begin
                  s_next.cnt = evt.window_time;
                  // Abort clear: double detection carries on
                  s_next.state = s_reg.lat_abort ? TEC_SQ_IDLE : TEC_SQ_WINDOW;
               end else begin
                  s_next.cnt = s_reg.cnt - 8'h01;
               end
            end
         end
         TEC_SQ_WINDOW: begin
            if (|pulse_done) begin
               s_next.double_evt = 1'b1;
               s_next.axis = pulse_done;
               s_next.negative = pulse_neg & pulse_done;
               s_next.state = TEC_SQ_IDLE;
            end else if (tick) begin
               if (s_reg.cnt == 8'h00) begin
                  s_next.state = TEC_SQ_IDLE;
               end else begin
                  s_next.cnt = s_reg.cnt - 8'h01;
               end
            end
         end
         default: begin
            s_next.state = TEC_SQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_reg <= '{state: TEC_SQ_IDLE, default: '0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign evt.single_evt = s_reg.single_evt;
   assign evt.double_evt = s_reg.double_evt;
   assign evt.axis = s_reg.axis;
   assign evt.negative = s_reg.negative;

   chk_latency_no_event: assert property (@(posedge clk) disable iff (reset)
      s_reg.state == TEC_SQ_LATENCY |=> !s_reg.single_evt && !s_reg.double_evt)
      else $error("event reported during latency interval");
   chk_abort_suspends: assert property (@(posedge clk) disable iff (reset)
      s_reg.state == TEC_SQ_LATENCY && s_reg.lat_abort && tick && s_reg.cnt == 8'h00
      |=> s_reg.state == TEC_SQ_IDLE)
      else $error("aborted double tap still entered window");
   chk_no_abort_continues: assert property (@(posedge clk) disable iff (reset)
      s_reg.state == TEC_SQ_LATENCY && !evt.double_tap_abort && !s_reg.lat_abort
      && tick && s_reg.cnt == 8'h00 |=> s_reg.state == TEC_SQ_WINDOW)
      else $error("double tap detection dropped with abort clear");
endmodule

// >>> rtl/tec_tap_event_top.sv
// Tap event configuration and status registers with tap sequencer
// Behaviour
// - Six per-axis single/double enables, reset disabled
// - Flags raised only for enabled axis and type
// - Abort clear: double detection continues after latency
// - Abort set: latency pulse suspends double detection
// - Latch bit holds event flags until read
// - Event-active bit set by any enabled event, reset 0
// - Bits 6..4 flag Z, Y, X events
// - Bit 3 tells double from single tap
// - Bits 2..0 give Z, Y, X polarity
// - Latched and active: status bits frozen until read
// - Status read clears all status bits and drops interrupt, unless an enabled event arrives in the same cycle
// - Pulses not reported during latency after first pulse
`timescale 1ns/1ps
module tec_tap_event_top
   import tec_pkg::*;
#(
   parameter int STEP_CYCLES = TEC_STEP_CYCLES
)(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register port behind the serial interface
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Pulse detector, bit 2 Z, bit 1 Y, bit 0 X
   input wire logic [2:0] pulse_start,
   input wire logic [2:0] pulse_done,
   input wire logic [2:0] pulse_neg,
   // Timer settings in steps
   input wire logic [7:0] tap_latency_time,
   input wire logic [7:0] window_time,
   // Interrupt request
   output logic tap_irq
);
   localparam int DIV_W = (STEP_CYCLES > 1) ? $clog2(STEP_CYCLES) : 1;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(STEP_CYCLES - 1);

   typedef struct packed {
      logic [7:0] config_q;
      logic [7:0] status_q;
      logic [7:0] rdata;
      logic [DIV_W-1:0] div;
      logic tick;
   } tec_top_t;

   tec_top_t s_reg;
   tec_top_t s_next;

   tec_evt_if evt ();

   logic [2:0] sgl_en;
   logic [2:0] dbl_en;
   logic [2:0] hit_axes;
   logic wr_config;
   logic rd_status;
   logic rd_config;

   assign sgl_en = {s_reg.config_q[TEC_CFG_Z_SGL], s_reg.config_q[TEC_CFG_Y_SGL],
                    s_reg.config_q[TEC_CFG_X_SGL]};
   assign dbl_en = {s_reg.config_q[TEC_CFG_Z_DBL], s_reg.config_q[TEC_CFG_Y_DBL],
                    s_reg.config_q[TEC_CFG_X_DBL]};
   // Only enabled axis and event type may report
   assign hit_axes = (evt.single_evt ? (evt.axis & sgl_en) : 3'h0)
                   | (evt.double_evt ? (evt.axis & dbl_en) : 3'h0);
   assign wr_config = reg_wr && reg_addr == TEC_CONFIG_ADDR;
   assign rd_status = reg_rd && reg_addr == TEC_STATUS_ADDR;
   assign rd_config = reg_rd && reg_addr == TEC_CONFIG_ADDR;

   assign evt.double_tap_abort = s_reg.config_q[TEC_CFG_ABORT];
   assign evt.tap_latency_time = tap_latency_time;
   assign evt.window_time = window_time;

   tec_tap_seq u_seq (
      .clk(clk),
      .reset(reset),
      .tick(s_reg.tick),
      .pulse_start(pulse_start),
      .pulse_done(pulse_done),
      .pulse_neg(pulse_neg),
      .evt(evt)
   );

   always_comb begin
      logic [7:0] base;
      logic frozen;
      base = 8'h00;
      frozen = 1'b0;
      s_next = s_reg;
      // Timer step divider
      s_next.tick = 1'b0;
      if (s_reg.div == DIV_LAST) begin
         s_next.div = '0;
         s_next.tick = 1'b1;
      end else begin
         s_next.div = s_reg.div + DIV_W'(1);
      end
      // Writes reach configuration only; status ignores them
      if (wr_config) begin
         s_next.config_q = reg_wdata;
      end
      // Read data captured before the clear
      if (rd_status) begin
         s_next.rdata = s_reg.status_q;
      end else if (rd_config) begin
         s_next.rdata = s_reg.config_q;
      end else if (reg_rd) begin
         s_next.rdata = 8'h00;
      end
      base = rd_status ? 8'h00 : s_reg.status_q;
      frozen = s_reg.config_q[TEC_CFG_LATCH] && base[TEC_ST_ACTIVE];
      // A new event beats a clearing read in the same cycle
      if (|hit_axes) begin
         if (frozen) begin
            s_next.status_q = base;
         end else begin
            s_next.status_q = {1'b1, hit_axes, evt.double_evt,
                               evt.negative & hit_axes};
         end
      end else begin
         s_next.status_q = base;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_reg.config_q <= TEC_CONFIG_RST;
         s_reg.status_q <= TEC_STATUS_RST;
         s_reg.rdata <= TEC_RDATA_RST;
         s_reg.div <= '0;
         s_reg.tick <= 1'b0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign reg_rdata = s_reg.rdata;
   assign tap_irq = s_reg.status_q[TEC_ST_ACTIVE];

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   chk_config_reset: assert property ($fell(reset) |-> s_reg.config_q == 8'h00)
      else $error("configuration not disabled after reset");
   chk_config_write: assert property (wr_config |=> s_reg.config_q == $past(reg_wdata))
      else $error("configuration write not stored");
   chk_disabled_quiet: assert property (s_reg.config_q[5:0] == 6'h00 && s_reg.status_q == 8'h00
      && !reg_wr |=> s_reg.status_q == 8'h00)
      else $error("flag raised with all enables off");
   chk_event_sets: assert property (|hit_axes && !(s_reg.config_q[TEC_CFG_LATCH]
      && s_reg.status_q[TEC_ST_ACTIVE] && !rd_status)
      |=> s_reg.status_q[7] && s_reg.status_q[6:4] == $past(hit_axes)
      && s_reg.status_q[3] == $past(evt.double_evt)
      && s_reg.status_q[2:0] == ($past(evt.negative) & $past(hit_axes)))
      else $error("status not loaded from event");
   chk_latched_freeze: assert property (s_reg.config_q[TEC_CFG_LATCH] && s_reg.status_q[7]
      && !rd_status |=> s_reg.status_q == $past(s_reg.status_q))
      else $error("latched status changed before read");
   chk_read_clears: assert property (rd_status && !(|hit_axes)
      |=> s_reg.status_q == 8'h00 && !tap_irq
      && reg_rdata == $past(s_reg.status_q))
      else $error("status read did not clear");
   chk_status_readonly: assert property (reg_wr && reg_addr == TEC_STATUS_ADDR && !(|hit_axes)
      && !rd_status |=> s_reg.status_q == $past(s_reg.status_q))
      else $error("status changed by a write");
   chk_irq_follows: assert property ((|hit_axes || (tap_irq && !rd_status)) |=> tap_irq
      && tap_irq == s_reg.status_q[TEC_ST_ACTIVE] && s_reg.status_q[6:4] != 3'h0)
      else $error("interrupt does not follow event flag");
endmodule

// >>> testbench/tec_tap_source.sv
// Pulse detector model feeding start, end and polarity pulses
`timescale 1ns/1ps
module tec_tap_source (
   // Clock
   input wire logic clk,
   // Pulses to the block
   output logic [2:0] pulse_start,
   output logic [2:0] pulse_done,
   output logic [2:0] pulse_neg
);
   initial begin
      pulse_start = 3'h0;
      pulse_done = 3'h0;
      pulse_neg = 3'h0;
   end
   // One pulse: start, a cycle above threshold, then a valid end
   task automatic tap(input logic [2:0] axis, input logic [2:0] neg);
      @(negedge clk);
      pulse_start = axis;
      @(negedge clk);
      pulse_start = 3'h0;
      @(negedge clk);
      pulse_done = axis;
      pulse_neg = neg;
      @(negedge clk);
      pulse_done = 3'h0;
      // Polarity is only meaningful with the end pulse
      pulse_neg = ~neg;
   endtask
endmodule

// >>> testbench/tb_tec_tap_event_top.sv
// Self-checking bench for the tap event configuration and status block
`timescale 1ns/1ps
module tb_tec_tap_event_top;
   import tec_pkg::*;
   localparam int STEP = 4;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic [2:0] pulse_start;
   logic [2:0] pulse_done;
   logic [2:0] pulse_neg;
   logic [7:0] tap_latency_time = 8'h02;
   logic [7:0] window_time = 8'h08;
   logic tap_irq;
   int errors = 0;
   int n_checks = 0;

   always #2 clk = ~clk;

   tec_tap_source src (.clk(clk), .pulse_start(pulse_start), .pulse_done(pulse_done),
      .pulse_neg(pulse_neg));

   tec_tap_event_top #(.STEP_CYCLES(STEP)) dut (.clk(clk), .reset(reset),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .pulse_start(pulse_start), .pulse_done(pulse_done),
      .pulse_neg(pulse_neg), .tap_latency_time(tap_latency_time),
      .window_time(window_time), .tap_irq(tap_irq));

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      check(what, exp, reg_rdata);
   endtask

   task automatic irq(input logic e);
      check("tap_irq", {7'h00, e}, {7'h00, tap_irq});
   endtask

   task automatic settle(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic complete_run;
      $display("Checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      #20000;
      errors++;
      $display("Error watchdog expected done seen timeout");
      complete_run();
   end

   initial begin
      repeat (16) @(posedge clk);
      @(negedge clk);
      reset = 1'b0;
      rd(TEC_CONFIG_ADDR, TEC_CONFIG_RST, "config reset");
      rd(TEC_STATUS_ADDR, TEC_STATUS_RST, "status reset");
      irq(1'b0);
      wr(TEC_CONFIG_ADDR, 8'hff);
      rd(TEC_CONFIG_ADDR, 8'hff, "config all ones");
      wr(TEC_STATUS_ADDR, 8'hff);
      wr(8'h30, 8'h5a);
      rd(TEC_STATUS_ADDR, 8'h00, "status write ignored");
      rd(8'h30, 8'h00, "unmapped read");
      rd(TEC_CONFIG_ADDR, 8'hff, "config after unmapped write");
      // Negative single tap per axis, only that axis enabled
      for (int i = 0; i < 3; i++) begin
         wr(TEC_CONFIG_ADDR, 8'h01 << (2 * i));
         src.tap(3'h1 << i, 3'h1 << i);
         settle(3);
         irq(1'b1);
         rd(TEC_STATUS_ADDR, 8'h80 | (8'h10 << i) | (8'h01 << i), "single status");
         irq(1'b0);
         rd(TEC_STATUS_ADDR, 8'h00, "status after read");
         settle(60);
      end
      // Type not enabled for the tapped axis
      wr(TEC_CONFIG_ADDR, 8'h3e);
      src.tap(3'h1, 3'h0);
      settle(60);
      rd(TEC_STATUS_ADDR, 8'h00, "disabled single tap");
      irq(1'b0);
      // Double tap with a short pulse inside latency, abort off then on
      for (int a = 0; a < 2; a++) begin
         wr(TEC_CONFIG_ADDR, {a[0], 7'h20});
         src.tap(3'h4, 3'h0);
         src.tap(3'h4, 3'h0);
         settle(10);
         src.tap(3'h4, 3'h0);
         settle(3);
         rd(TEC_STATUS_ADDR, (a == 0) ? 8'hc8 : 8'h00, "double status");
         settle(60);
      end
      // Second event overwrites without latch, is ignored with latch
      for (int l = 0; l < 2; l++) begin
         wr(TEC_CONFIG_ADDR, {1'b0, l[0], 6'h11});
         src.tap(3'h1, 3'h0);
         settle(60);
         src.tap(3'h4, 3'h4);
         settle(3);
         rd(TEC_STATUS_ADDR, (l == 0) ? 8'hc4 : 8'h90, "second status");
         settle(60);
      end
      complete_run();
   end
endmodule
